//--- design/capture_timer_map.vh
// register map and constants for the two-channel capture/compare timer
//
// Summary of operation
// - overflow irq when flag and enable; reset clears
// - channel irq when flag set and enabled
// - keeps counting in wait; irqs can wake
// - break freezes counter, blocks captures
// - break clears flags only with permit set
// - pre-break first step finishes after break
// - counter equal modulo sets flag, restarts zero
// - overflow flag cleared by read-then-write zero
// - halt stops counting; reset sets halt
// - halt blocks input captures
// - clear bit zeroes counter, prescaler; reads zero
// - halt plus clear stops counter at zero
// - divider select picks bus clock divided 1..64
// - high byte read latches low byte
// - reset and clear bit zero counter
// - modulo high write blocks overflow until low
// - reset sets modulo to all ones
// - channel flag on active edge or compare
// - channel flag cleared by read-then-write zero
// - two channels; only channel 0 buffered
// - reset clears channel irq enables
`ifndef CAPTURE_TIMER_MAP_VH
`define CAPTURE_TIMER_MAP_VH

// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define ADDR_CTL_STATUS 3'h0
`define ADDR_CNT_HIGH 3'h1
`define ADDR_CNT_LOW 3'h2
`define ADDR_MOD_HIGH 3'h3
`define ADDR_MOD_LOW 3'h4
`define ADDR_CH0_STATUS 3'h5
`define ADDR_CH1_STATUS 3'h6

// ---------------------------------------------
// control/status fields
// ---------------------------------------------
`define BIT_OVF_FLAG 7
`define BIT_OVF_IRQ_EN 6
`define BIT_HALT 5
`define BIT_CLEAR 4
`define DIV_SEL_NONE 3'h7

// ---------------------------------------------
// channel fields
// ---------------------------------------------
`define BIT_CH_FLAG 7
`define BIT_CH_IRQ_EN 6
`define BIT_CH_BUFFERED 5
`define BIT_CH_MODE_A 4
`define BIT_CH_EDGE_B 3
`define BIT_CH_EDGE_A 2

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define RST_HALT 1'b1
`define RST_DIV_SEL 3'h0
`define RST_MODULO 16'hffff
`define RST_CH_CFG 7'h00
`define RST_COUNT 16'h0000
`define RST_PRESCALE 6'h00

`endif

//--- design/capture_timer.v
// two-channel 16-bit capture/compare timer with byte register port
`include "capture_timer_map.vh"
`default_nettype none

module capture_timer (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // register port
  input wire [2:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output wire [7:0] rdData,
  // system state
  input wire breakState,
  input wire breakClearPermit,
  // channel events
  input wire channel0Pin,
  input wire channel1Pin,
  input wire [1:0] compareMatch,
  // requests and status
  output wire overflowIrq,
  output wire [1:0] channelIrq,
  output wire [1:0] captureStrobe,
  output wire [15:0] countValue
);

  // ---------------------------------------------
  // functions
  // ---------------------------------------------
  function [5:0] divMask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: divMask = 6'h00;
        3'h1: divMask = 6'h01;
        3'h2: divMask = 6'h03;
        3'h3: divMask = 6'h07;
        3'h4: divMask = 6'h0f;
        3'h5: divMask = 6'h1f;
        default: divMask = 6'h3f;
      endcase
    end
  endfunction

  function edgeHit;
    input [1:0] edgeSel;
    input rise;
    input fall;
    begin
      edgeHit = (edgeSel[0] & rise) | (edgeSel[1] & fall);
    end
  endfunction

  // one register access at a given offset
  function regHit;
    input strobe;
    input [2:0] where;
    input [2:0] target;
    begin
      regHit = strobe && (where == target);
    end
  endfunction

  // input capture needs an active edge selected
  function capMode;
    input [6:0] cfg;
    begin
      capMode = !cfg[`BIT_CH_BUFFERED] && !cfg[`BIT_CH_MODE_A] &&
        (cfg[`BIT_CH_EDGE_B:`BIT_CH_EDGE_A] != 2'b00);
    end
  endfunction

  function cmpMode;
    input [6:0] cfg;
    begin
      cmpMode = cfg[`BIT_CH_BUFFERED] || cfg[`BIT_CH_MODE_A];
    end
  endfunction

  // ---------------------------------------------
  // reset release
  // ---------------------------------------------
  reg rstMeta_ff;
  reg rstSync_ff;
  wire rstN;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  assign rstN = rstSync_ff;

  // ---------------------------------------------
  // access decode
  // ---------------------------------------------
  wire wrCtl = regHit(wrStrobe, addr, `ADDR_CTL_STATUS);
  wire rdCtl = regHit(rdStrobe, addr, `ADDR_CTL_STATUS);
  wire rdCntHigh = regHit(rdStrobe, addr, `ADDR_CNT_HIGH);
  wire rdCntLow = regHit(rdStrobe, addr, `ADDR_CNT_LOW);
  wire wrModHigh = regHit(wrStrobe, addr, `ADDR_MOD_HIGH);
  wire wrModLow = regHit(wrStrobe, addr, `ADDR_MOD_LOW);
  // flags may change by software outside break or with permit
  wire flagAccessOk = !breakState || breakClearPermit;

  // ---------------------------------------------
  // control register
  // ---------------------------------------------
  reg halt_ff;
  reg ovfIrqEn_ff;
  reg [2:0] divSel_ff;
  wire clearPulse = wrCtl && wrData[`BIT_CLEAR];

  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      halt_ff <= `RST_HALT;
      ovfIrqEn_ff <= 1'b0;
      divSel_ff <= `RST_DIV_SEL;
    end else if (wrCtl) begin
      halt_ff <= wrData[`BIT_HALT];
      ovfIrqEn_ff <= wrData[`BIT_OVF_IRQ_EN];
      divSel_ff <= wrData[2:0];
    end
  end

  // ---------------------------------------------
  // modulo registers
  // ---------------------------------------------
  reg [15:0] modulo_ff;
  reg modLock_ff;

  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      modulo_ff <= `RST_MODULO;
      modLock_ff <= 1'b0;
    end else if (wrModHigh) begin
      modulo_ff[15:8] <= wrData;
      modLock_ff <= 1'b1;
    end else if (wrModLow) begin
      modulo_ff[7:0] <= wrData;
      modLock_ff <= 1'b0;
    end
  end

  // ---------------------------------------------
  // prescaler and counter
  // ---------------------------------------------
  reg [5:0] prescale_ff;
  reg [15:0] count_ff;
  // wait mode does not gate this path
  wire running = !halt_ff && !breakState;
  wire [5:0] mask = divMask(divSel_ff);
  wire tick = running && (divSel_ff != `DIV_SEL_NONE) &&
    ((prescale_ff & mask) == mask);
  wire atModulo = (count_ff == modulo_ff);
  // counter still wraps while the flag is held off
  wire ovfEvent = tick && atModulo && !modLock_ff;

  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prescale_ff <= `RST_PRESCALE;
      count_ff <= `RST_COUNT;
    end else if (clearPulse) begin
      prescale_ff <= `RST_PRESCALE;
      count_ff <= `RST_COUNT;
    end else if (running) begin
      prescale_ff <= prescale_ff + 6'h01;
      if (tick) begin
        count_ff <= atModulo ? 16'h0000 : count_ff + 16'h0001;
      end
    end
  end

  assign countValue = count_ff;

  // ---------------------------------------------
  // counter readback latch
  // ---------------------------------------------
  reg [7:0] lowBuf_ff;
  reg lowLatched_ff;

  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      lowBuf_ff <= 8'h00;
      lowLatched_ff <= 1'b0;
    end else if (clearPulse) begin
      lowBuf_ff <= 8'h00;
      lowLatched_ff <= 1'b0;
    end else if (rdCntHigh && !lowLatched_ff) begin
      lowBuf_ff <= count_ff[7:0];
      lowLatched_ff <= 1'b1;
    end else if (rdCntLow) begin
      lowLatched_ff <= 1'b0;
    end
  end

  // ---------------------------------------------
  // overflow flag
  // ---------------------------------------------
  reg ovfFlag_ff;
  reg ovfArm_ff;
  reg ovfIrq_ff;
  wire ovfClear = wrCtl && !wrData[`BIT_OVF_FLAG] && ovfArm_ff &&
    flagAccessOk;

  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ovfFlag_ff <= 1'b0;
      ovfArm_ff <= 1'b0;
    end else begin
      if (ovfEvent) begin
        ovfFlag_ff <= 1'b1;
        ovfArm_ff <= 1'b0;
      end else if (ovfClear) begin
        ovfFlag_ff <= 1'b0;
        ovfArm_ff <= 1'b0;
      end else if (rdCtl && ovfFlag_ff && flagAccessOk) begin
        ovfArm_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // interrupt requests
  // ---------------------------------------------
  // requests lag their flag by one clock
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ovfIrq_ff <= 1'b0;
    end else begin
      ovfIrq_ff <= ovfFlag_ff && ovfIrqEn_ff;
    end
  end

  assign overflowIrq = ovfIrq_ff;

  // ---------------------------------------------
  // channels
  // ---------------------------------------------
  wire [1:0] pinIn = {channel1Pin, channel0Pin};
  wire [15:0] chRead;
  wire ch0Buffered;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : chan
      reg pinMeta_ff;
      reg pinSync_ff;
      reg pinPrev_ff;
      reg [6:0] cfg_ff;
      reg flag_ff;
      reg arm_ff;
      reg irq_ff;
      reg capStb_ff;
      wire [2:0] chAddr = (i == 0) ? `ADDR_CH0_STATUS : `ADDR_CH1_STATUS;
      wire wrHit = regHit(wrStrobe, addr, chAddr);
      wire rdHit = regHit(rdStrobe, addr, chAddr);
      // channel 1 is taken over while channel 0 runs buffered
      wire active = (i == 0) ? 1'b1 : !ch0Buffered;
      wire [1:0] edgeSel = {cfg_ff[`BIT_CH_EDGE_B], cfg_ff[`BIT_CH_EDGE_A]};
      wire isCapture = capMode(cfg_ff);
      wire isCompare = cmpMode(cfg_ff);
      wire rise = pinSync_ff && !pinPrev_ff;
      wire fall = !pinSync_ff && pinPrev_ff;
      wire capEvent = active && isCapture && !halt_ff && !breakState &&
        edgeHit(edgeSel, rise, fall);
      wire cmpEvent = active && isCompare && !breakState &&
        compareMatch[i];
      wire chEvent = capEvent || cmpEvent;
      wire chClear = wrHit && !wrData[`BIT_CH_FLAG] && arm_ff &&
        flagAccessOk;
      // only channel 0 keeps the buffered mode bit
      wire [6:0] cfgMask = (i == 0) ? 7'h7f : 7'h5f;

      always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
          pinMeta_ff <= 1'b0;
          pinSync_ff <= 1'b0;
          pinPrev_ff <= 1'b0;
        end else begin
          pinMeta_ff <= pinIn[i];
          pinSync_ff <= pinMeta_ff;
          pinPrev_ff <= pinSync_ff;
        end
      end

      always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
          cfg_ff <= `RST_CH_CFG;
        end else if (wrHit) begin
          cfg_ff <= wrData[6:0] & cfgMask;
        end
      end

      always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
          flag_ff <= 1'b0;
          arm_ff <= 1'b0;
        end else begin
          if (chEvent) begin
            flag_ff <= 1'b1;
            arm_ff <= 1'b0;
          end else if (chClear) begin
            flag_ff <= 1'b0;
            arm_ff <= 1'b0;
          end else if (rdHit && flag_ff && flagAccessOk) begin
            arm_ff <= 1'b1;
          end
        end
      end

      // strobe trails the event by one clock; request trails the flag by one clock
      always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
          irq_ff <= 1'b0;
          capStb_ff <= 1'b0;
        end else begin
          irq_ff <= flag_ff && cfg_ff[`BIT_CH_IRQ_EN];
          capStb_ff <= capEvent;
        end
      end

      assign chRead[i*8 +: 8] = {flag_ff, cfg_ff};
      assign channelIrq[i] = irq_ff;
      assign captureStrobe[i] = capStb_ff;
    end
  endgenerate

  assign ch0Buffered = chRead[`BIT_CH_BUFFERED];

  // ---------------------------------------------
  // read data
  // ---------------------------------------------
  reg [7:0] rdMux;
  reg [7:0] rdData_ff;

  always @* begin
    case (addr)
      `ADDR_CTL_STATUS: rdMux = {ovfFlag_ff, ovfIrqEn_ff, halt_ff,
        1'b0, 1'b0, divSel_ff};
      `ADDR_CNT_HIGH: rdMux = count_ff[15:8];
      `ADDR_CNT_LOW: rdMux = lowLatched_ff ? lowBuf_ff :
        count_ff[7:0];
      `ADDR_MOD_HIGH: rdMux = modulo_ff[15:8];
      `ADDR_MOD_LOW: rdMux = modulo_ff[7:0];
      `ADDR_CH0_STATUS: rdMux = chRead[7:0];
      `ADDR_CH1_STATUS: rdMux = chRead[15:8];
      default: rdMux = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= rdStrobe ? rdMux : 8'h00;
    end
  end

  assign rdData = rdData_ff;

endmodule

`default_nettype wire

//--- dv/capture_timer_props.sv
// port-level assertions for the capture timer
`default_nettype none
module capture_timer_props (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  // state and requests
  input wire logic breakState,
  input wire logic overflowIrq,
  input wire logic [1:0] channelIrq,
  input wire logic [1:0] captureStrobe,
  input wire logic [15:0] countValue
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  property p_ovf_irq;
    rdStrobe && addr == 3'h0 |=> overflowIrq == (rdData[7] & rdData[6])
      && !rdData[4];
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("ovf irq");
  property p_ch0_irq;
    rdStrobe && addr == 3'h5 |=> channelIrq[0] == (rdData[7] & rdData[6]);
  endproperty
  a_ch0_irq: assert property (p_ch0_irq) else $error("ch0 irq");
  property p_ch1_irq;
    rdStrobe && addr == 3'h6 |=> channelIrq[1] == (rdData[7] & rdData[6]);
  endproperty
  a_ch1_irq: assert property (p_ch1_irq) else $error("ch1 irq");
  property p_freeze;
    $past(breakState) && !$past(wrStrobe) |-> $stable(countValue);
  endproperty
  a_freeze: assert property (p_freeze) else $error("break count");
  property p_cap_break;
    |captureStrobe |-> !$past(breakState);
  endproperty
  a_cap_break: assert property (p_cap_break) else $error("break cap");
  property p_step;
    countValue != $past(countValue) |->
      countValue == $past(countValue) + 16'h1 || countValue == 16'h0;
  endproperty
  a_step: assert property (p_step) else $error("count step");
  property p_clear;
    wrStrobe && addr == 3'h0 && wrData[4] |=> countValue == 16'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_halt_clear;
    wrStrobe && addr == 3'h0 && wrData[5:4] == 2'h3 |=> !wrStrobe
      |=> countValue == 16'h0;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("halt");
  property p_cnt_read;
    rdStrobe && addr == 3'h1 |=> rdData == 8'($past(countValue) >> 8);
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("cnt hi");
endmodule
bind capture_timer capture_timer_props chk (.clock, .reset_n, .addr,
  .wrData, .wrStrobe, .rdStrobe, .rdData, .breakState, .overflowIrq,
  .channelIrq, .captureStrobe, .countValue);
`default_nettype wire

//--- dv/capture_timer_tb.sv
// self-checking bench for the capture timer
`default_nettype none
module capture_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wrData = 8'h0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic breakState = 1'b0;
  logic breakClearPermit = 1'b0;
  logic [1:0] pins = 2'h0;
  logic [1:0] compareMatch = 2'h0;
  wire [7:0] rdData;
  wire overflowIrq;
  wire [1:0] channelIrq;
  wire [1:0] captureStrobe;
  wire [15:0] countValue;
  int miscompares = 0;
  int nTests = 0;
  int cycles = 0;
  int seed = 44298;
  int m;
  int n;
  int caps = 0;
  capture_timer dut (.clock(clock), .reset_n(reset_n), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .breakState(breakState),
    .breakClearPermit(breakClearPermit), .channel0Pin(pins[0]),
    .channel1Pin(pins[1]), .compareMatch(compareMatch),
    .overflowIrq(overflowIrq), .channelIrq(channelIrq),
    .captureStrobe(captureStrobe), .countValue(countValue));
  // ----
  // helpers
  // ----
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end
  always @(posedge clock) begin
    if (captureStrobe[0] === 1'b1)
      caps++;
  end
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("tests %0d miscompares %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1 chk({8'h0, rdData}, {8'h0, exp});
    @(posedge clock);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic waitc(input logic [15:0] v);
    n = 0;
    while (countValue !== v && n < 5000) begin
      @(negedge clock);
      n++;
    end
  endtask
  // ----
  // sequence
  // ----
  initial begin
    cyc(5);
    reset_n <= 1'b1;
    cyc(4);
    rc(3'h0, 8'h20);
    rc(3'h3, 8'hff);
    rc(3'h4, 8'hff);
    rc(3'h5, 8'h00);
    rc(3'h6, 8'h00);
    rc(3'h7, 8'h00);
    wr(3'h1, 8'h55);
    rc(3'h1, 8'h00);
    rc(3'h2, 8'h00);
    m = 2 + (rnd() & 5);
    wr(3'h3, 8'h00);
    wr(3'h4, m[7:0]);
    wr(3'h0, 8'h50);
    waitc(16'h1);
    n = 1;
    repeat (3 * m) begin
      @(negedge clock);
      n = (n == m) ? 0 : n + 1;
      chk(countValue, 16'(n));
    end
    @(posedge clock);
    chk({15'h0, overflowIrq}, 16'h1);
    wr(3'h0, 8'h60);
    rc(3'h0, 8'he0);
    wr(3'h0, 8'he0);
    rc(3'h0, 8'he0);
    wr(3'h0, 8'h60);
    rc(3'h0, 8'h60);
    chk({15'h0, overflowIrq}, 16'h0);
    wr(3'h0, 8'h40);
    cyc(m + 2);
    rc(3'h0, 8'hc0);
    cyc(m + 2);
    wr(3'h0, 8'h20);
    rc(3'h0, 8'ha0);
    wr(3'h0, 8'h30);
    cyc(3);
    chk(countValue, 16'h0);
    rc(3'h0, 8'h20);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h00);
    cyc(30);
    wr(3'h0, 8'h20);
    rc(3'h0, 8'h20);
    wr(3'h4, m[7:0]);
    wr(3'h0, 8'h00);
    cyc(30);
    wr(3'h0, 8'h20);
    rc(3'h0, 8'ha0);
    breakState <= 1'b1;
    cyc(1);
    wr(3'h0, 8'h20);
    rc(3'h0, 8'ha0);
    breakState <= 1'b0;
    cyc(1);
    wr(3'h0, 8'h20);
    rc(3'h0, 8'h20);
    wr(3'h0, 8'h00);
    cyc(m + 3);
    breakState <= 1'b1;
    breakClearPermit <= 1'b1;
    cyc(1);
    rc(3'h0, 8'h80);
    wr(3'h0, 8'h20);
    rc(3'h0, 8'h20);
    breakState <= 1'b0;
    breakClearPermit <= 1'b0;
    cyc(1);
    rc(3'h0, 8'h20);
    wr(3'h0, 8'h30);
    wr(3'h3, 8'hff);
    wr(3'h4, 8'hff);
    for (int s = 0; s < 8; s++) begin
      wr(3'h0, 8'h30);
      wr(3'h0, 8'(s));
      waitc(16'h1);
      waitc(16'h2);
      chk(16'(n), s == 7 ? 16'h1388 : 16'(1 << s));
      @(posedge clock);
    end
    wr(3'h0, 8'h30);
    wr(3'h0, 8'h03);
    waitc(16'hfe);
    @(posedge clock);
    rc(3'h1, 8'h00);
    waitc(16'h101);
    @(posedge clock);
    rc(3'h1, 8'h01);
    rc(3'h2, 8'hfe);
    wr(3'h0, 8'h20);
    wr(3'h5, 8'h44);
    pins[0] <= 1'b1;
    cyc(6);
    rc(3'h5, 8'h44);
    pins[0] <= 1'b0;
    cyc(6);
    wr(3'h0, 8'h00);
    pins[0] <= 1'b1;
    cyc(6);
    chk({14'h0, channelIrq}, 16'h1);
    rc(3'h5, 8'hc4);
    pins[0] <= 1'b0;
    cyc(6);
    pins[0] <= 1'b1;
    cyc(6);
    wr(3'h5, 8'h44);
    rc(3'h5, 8'hc4);
    wr(3'h5, 8'h44);
    rc(3'h5, 8'h44);
    pins[0] <= 1'b0;
    cyc(6);
    rc(3'h5, 8'h44);
    breakState <= 1'b1;
    pins[0] <= 1'b1;
    cyc(6);
    breakState <= 1'b0;
    cyc(2);
    rc(3'h5, 8'h44);
    wr(3'h6, 8'h10);
    compareMatch <= 2'h2;
    cyc(1);
    compareMatch <= 2'h0;
    cyc(2);
    rc(3'h6, 8'h90);
    chk({14'h0, channelIrq}, 16'h0);
    wr(3'h6, 8'h50);
    rc(3'h6, 8'h50);
    compareMatch <= 2'h2;
    cyc(1);
    compareMatch <= 2'h0;
    cyc(3);
    chk({14'h0, channelIrq}, 16'h2);
    chk(16'(caps), 16'h2);
    finish_test();
  end
endmodule
`default_nettype wire
